// File: include/wmg_pkg.sv
`default_nettype none
// Shared constants of the waveform marker generator
package wmg_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FIRST = 8'h04;
	localparam logic [7:0] OFS_LAST = 8'h08;
	localparam logic [7:0] OFS_SKIP = 8'h0C;
	localparam logic [7:0] OFS_SEGLEN = 8'h10;
	localparam logic [7:0] OFS_CFG = 8'h14;
	localparam logic [7:0] OFS_STAT = 8'h18;
	// Control fields
	localparam int CTL_SEL_LSB = 0;
	localparam int CTL_OP_LSB = 2;
	localparam int CTL_APPLY = 4;
	localparam int CTL_BUSY = 8;
	// Configuration fields
	localparam int CFG_POL_LSB = 0;
	localparam int CFG_BLK_LSB = 4;
	localparam int CFG_HLD_LSB = 8;
	localparam int CFG_RES = 16;
	localparam int CFG_EN_LSB = 20;
	// Status fields
	localparam int ST_BUSY = 0;
	localparam int ST_REFUSED = 1;
	localparam int ST_PTR_LSB = 16;
	// Values after reset
	localparam logic [3:0] POL_RST = 4'h0;
	localparam logic [3:0] EN_RST = 4'hF;
	localparam logic [2:0] RT_NONE = 3'h0;
	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Edit operations
	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_SET = 2'b01,
		OP_CLR = 2'b10,
		OP_FIRST = 2'b11
	} wmg_op_e;
	// Edit engine states
	typedef enum logic {
		ES_IDLE = 1'b0,
		ES_RUN = 1'b1
	} wmg_es_e;
endpackage
`default_nettype wire

// File: rtl/wmg_bitmap.sv
`default_nettype none
// One marker's flag per sample point
module wmg_bitmap #(
	parameter int DEPTH = 1024,
	parameter int IW = 10
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic we,
	input wire logic [IW-1:0] wa,
	input wire logic wd,
	input wire logic [IW-1:0] ra,
	output logic rd
);
	// All flags in one state word
	typedef struct packed {
		logic [DEPTH-1:0] bits;
	} wmg_bm_s;
	wmg_bm_s s;
	wmg_bm_s next_s;

	// Read in step with the playback pointer
	assign rd = s.bits[ra];

	// Single point update, others untouched
	always_comb begin
		next_s = s;
		if (we) begin
			next_s.bits[wa] = wd;
		end
	end

	// No marker points after reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule
`default_nettype wire

// File: rtl/wmg_buf2.sv
`default_nettype none
// Two-entry buffer, full throughput with registered ready
module wmg_buf2 #(
	parameter int W = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	// Two slots and a fill count
	typedef struct packed {
		logic [W-1:0] d0;
		logic [W-1:0] d1;
		logic [1:0] cnt;
	} wmg_buf_s;
	wmg_buf_s s;
	wmg_buf_s next_s;
	logic push;
	logic pop;

	assign in_ready = (s.cnt != 2'd2);
	assign out_valid = (s.cnt != 2'd0);
	assign out_data = s.d0;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Shift on pop, write at first free slot
	always_comb begin
		next_s = s;
		if (pop) begin
			next_s.d0 = s.d1;
		end
		if (push) begin
			if ((s.cnt - 2'(pop)) == 2'd0) begin
				next_s.d0 = in_data;
			end else begin
				next_s.d1 = in_data;
			end
		end
		next_s.cnt = s.cnt + 2'(push) - 2'(pop);
	end

	// Empty after reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule
`default_nettype wire

// File: rtl/wmg_top.sv
`default_nettype none
// How it works
// - Setting ORs new points into bitmap
// - No points keeps event output low at positive polarity
// - Clear range resets first to last inclusive
// - Set range marks first to last inclusive
// - Equal first and last touches one point
// - Set-first marks sample one only
// - Skip N marks every (N+1)th point
// - Skip count clamped to last minus first
// - Skip used only by its own apply
// - Each marker drives its own event output
// - Routed blanking blanks on low, holds level
// - Blanking follows low level, any polarity
// - Negative polarity inverts marker output
// - Polarity per marker, positive by default
// - Edits refused unless segment resident
// - Level loop samples while marker high
// - Per-marker enable masks marker output
module wmg_top
	import wmg_pkg::*;
#(
	parameter int DEPTH = 1024,
	parameter int PW = 16
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic PLAY,
	input wire logic EVT_READY,
	output logic [3:0] EVENT,
	output logic RF_BLANK,
	output logic LEVEL_HOLD,
	output logic LEVEL_SAMPLE
);
	import wmg_pkg::*;
	localparam int IW = $clog2(DEPTH);

	// Whole block state
	typedef struct packed {
		logic aw_rdy;
		logic w_rdy;
		logic aw_ok;
		logic w_ok;
		logic [7:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_rdy;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [1:0] msel;
		wmg_op_e op;
		logic [PW-1:0] first;
		logic [PW-1:0] last;
		logic [PW-1:0] skip;
		logic [PW-1:0] seglen;
		logic [3:0] pol;
		logic [2:0] blk_rt;
		logic [2:0] hld_rt;
		logic resident;
		logic [3:0] men;
		logic refused;
		wmg_es_e es;
		wmg_op_e eop;
		logic [1:0] esel;
		logic [PW-1:0] eidx;
		logic [PW-1:0] elast;
		logic [PW-1:0] esk;
		logic [PW-1:0] ecnt;
		logic [PW-1:0] ptr;
		logic [3:0] ev;
		logic blank;
		logic hold;
		logic samp;
	} wmg_top_s;
	wmg_top_s s;
	wmg_top_s next_s;

	logic apply; // Apply strobe from a control write
	logic set_ref; // Edit refused this cycle
	logic clr_ref; // Software clears refused flag
	logic range_ok; // Requested range is legal
	logic [PW-1:0] span; // Last minus first
	logic [31:0] nv; // Merged write image
	wmg_op_e wr_op; // Operation field of the pending write
	logic [3:0] lvl; // Polarity adjusted levels
	logic [3:0] bm_we;
	logic [IW-1:0] bm_wa;
	logic bm_wd;
	logic [3:0] bm_rd;
	logic buf_iv;
	logic buf_ir;
	logic [3:0] buf_id;
	logic buf_ov;
	logic [3:0] buf_od;
	logic push;
	logic pop;

	// Register image as software reads it
	function automatic logic [31:0] reg_img(input wmg_top_s st,
			input logic [7:0] a);
		logic [31:0] v;
		v = '0;
		case (a)
			OFS_CTRL: begin
				v[CTL_SEL_LSB +: 2] = st.msel;
				v[CTL_OP_LSB +: 2] = st.op;
				v[CTL_BUSY] = (st.es == ES_RUN);
			end
			OFS_FIRST: v[PW-1:0] = st.first;
			OFS_LAST: v[PW-1:0] = st.last;
			OFS_SKIP: v[PW-1:0] = st.skip;
			OFS_SEGLEN: v[PW-1:0] = st.seglen;
			OFS_CFG: begin
				v[CFG_POL_LSB +: 4] = st.pol;
				v[CFG_BLK_LSB +: 3] = st.blk_rt;
				v[CFG_HLD_LSB +: 3] = st.hld_rt;
				v[CFG_RES] = st.resident;
				v[CFG_EN_LSB +: 4] = st.men;
			end
			OFS_STAT: begin
				v[ST_BUSY] = (st.es == ES_RUN);
				v[ST_REFUSED] = st.refused;
				v[ST_PTR_LSB +: PW] = st.ptr;
			end
			default: v = '0;
		endcase
		return v;
	endfunction

	// Byte lanes not strobed keep their old value
	function automatic logic [31:0] merge(input logic [31:0] o,
			input logic [31:0] d, input logic [3:0] b);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (b[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Write port driven only while the edit walks
	assign bm_wa = s.eidx[IW-1:0];
	assign bm_wd = (s.eop != OP_CLR);
	assign bm_we = (s.es == ES_RUN && s.ecnt == '0) ?
		4'(4'h1 << s.esel) : 4'h0;

	// One bitmap per marker
	for (genvar g = 0; g < 4; g++) begin : g_bm
		wmg_bitmap #(.DEPTH(DEPTH), .IW(IW)) u_bm (
			.clk(MCLK),
			.rst(RST),
			.we(bm_we[g]),
			.wa(bm_wa),
			.wd(bm_wd),
			.ra(s.ptr[IW-1:0]),
			.rd(bm_rd[g])
		);
	end

	// Playback stream, stalls when the buffer is full
	assign buf_iv = PLAY && s.seglen != '0 && s.seglen <= PW'(DEPTH);
	assign buf_id = bm_rd & s.men;
	assign push = buf_iv && buf_ir;
	assign pop = buf_ov && EVT_READY;
	assign lvl = buf_od ^ s.pol;

	wmg_buf2 #(.W(4)) u_buf (
		.clk(MCLK),
		.rst(RST),
		.in_valid(buf_iv),
		.in_ready(buf_ir),
		.in_data(buf_id),
		.out_valid(buf_ov),
		.out_ready(EVT_READY),
		.out_data(buf_od)
	);

	// Legal range check for the pending apply
	// Built from registered state only, so no loop through next_s
	always_comb begin
		nv = merge(reg_img(s, s.waddr), s.wdata, s.wstrb);
		wr_op = wmg_op_e'(nv[CTL_OP_LSB +: 2]);
		span = s.last - s.first;
		if (wr_op == OP_FIRST) begin
			range_ok = (s.seglen != '0);
		end else begin
			range_ok = s.first != '0 &&
				s.last >= s.first &&
				s.last <= s.seglen &&
				s.seglen <= PW'(DEPTH);
		end
	end

	// Bus slave, edit engine and output stage
	always_comb begin
		next_s = s;
		apply = 1'b0;
		set_ref = 1'b0;
		clr_ref = 1'b0;
		// Address and data taken in either order
		if (S_AXI_AWVALID && s.aw_rdy) begin
			next_s.aw_ok = 1'b1;
			next_s.aw_rdy = 1'b0;
			next_s.waddr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && s.w_rdy) begin
			next_s.w_ok = 1'b1;
			next_s.w_rdy = 1'b0;
			next_s.wdata = S_AXI_WDATA;
			next_s.wstrb = S_AXI_WSTRB;
		end
		// Both halves present: commit and answer
		if (s.aw_ok && s.w_ok && !s.bvalid) begin
			next_s.aw_ok = 1'b0;
			next_s.w_ok = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OKAY;
			case (s.waddr)
				OFS_CTRL: begin
					next_s.msel = nv[CTL_SEL_LSB +: 2];
					next_s.op = wr_op;
					apply = s.wstrb[0] && s.wdata[CTL_APPLY];
				end
				OFS_FIRST: next_s.first = nv[PW-1:0];
				OFS_LAST: next_s.last = nv[PW-1:0];
				OFS_SKIP: next_s.skip = nv[PW-1:0];
				OFS_SEGLEN: next_s.seglen = nv[PW-1:0];
				OFS_CFG: begin
					next_s.pol = nv[CFG_POL_LSB +: 4];
					next_s.blk_rt = nv[CFG_BLK_LSB +: 3];
					next_s.hld_rt = nv[CFG_HLD_LSB +: 3];
					next_s.resident = nv[CFG_RES];
					next_s.men = nv[CFG_EN_LSB +: 4];
				end
				OFS_STAT: begin
					clr_ref = s.wstrb[0] && s.wdata[ST_REFUSED];
				end
				default: next_s.bresp = RESP_SLVERR;
			endcase
		end
		if (s.bvalid && S_AXI_BREADY) begin
			next_s.bvalid = 1'b0;
			next_s.aw_rdy = 1'b1;
			next_s.w_rdy = 1'b1;
		end
		// Read answered one cycle after the address
		if (S_AXI_ARVALID && s.ar_rdy) begin
			next_s.ar_rdy = 1'b0;
			next_s.rvalid = 1'b1;
			next_s.rdata = reg_img(s, S_AXI_ARADDR);
			next_s.rresp = (S_AXI_ARADDR inside {OFS_CTRL, OFS_FIRST,
				OFS_LAST, OFS_SKIP, OFS_SEGLEN, OFS_CFG, OFS_STAT}) ?
				RESP_OKAY : RESP_SLVERR;
		end
		if (s.rvalid && S_AXI_RREADY) begin
			next_s.rvalid = 1'b0;
			next_s.ar_rdy = 1'b1;
		end
		// Edit engine walks one point per cycle
		case (s.es)
			ES_IDLE: begin
				if (apply) begin
					if (!s.resident || next_s.op == OP_NONE ||
							!range_ok) begin
						set_ref = 1'b1;
					end else begin
						next_s.es = ES_RUN;
						next_s.eop = next_s.op;
						next_s.esel = next_s.msel;
						next_s.ecnt = '0;
						if (next_s.op == OP_FIRST) begin
							next_s.eidx = '0;
							next_s.elast = '0;
							next_s.esk = '0;
						end else begin
							// Points are numbered from one
							next_s.eidx = next_s.first - 1'b1;
							next_s.elast = next_s.last - 1'b1;
							// Skip latched here only, never replayed
							if (next_s.op == OP_CLR) begin
								next_s.esk = '0;
							end else if (next_s.skip > span) begin
								next_s.esk = span;
							end else begin
								next_s.esk = next_s.skip;
							end
						end
					end
				end
			end
			ES_RUN: begin
				// A second apply while busy is refused
				if (apply) begin
					set_ref = 1'b1;
				end
				next_s.eidx = s.eidx + 1'b1;
				next_s.ecnt = (s.ecnt == s.esk) ? '0 : s.ecnt + 1'b1;
				if (s.eidx == s.elast) begin
					next_s.es = ES_IDLE;
				end
			end
			default: next_s.es = ES_IDLE;
		endcase
		// New refusal beats a clear in the same cycle
		next_s.refused = (s.refused && !clr_ref) || set_ref;
		// Sample pointer wraps at segment end
		if (!PLAY) begin
			next_s.ptr = '0;
		end else if (push) begin
			next_s.ptr = (s.ptr == s.seglen - 1'b1) ? '0 : s.ptr + 1'b1;
		end
		// Output stage, one sample per accepted slot
		if (pop) begin
			next_s.ev = lvl;
			next_s.blank = s.blk_rt != RT_NONE &&
				!lvl[2'(s.blk_rt - 3'd1)];
			next_s.samp = s.hld_rt != RT_NONE &&
				lvl[2'(s.hld_rt - 3'd1)];
			next_s.hold = next_s.blank || (s.hld_rt != RT_NONE &&
				!lvl[2'(s.hld_rt - 3'd1)]);
		end else if (!PLAY && !buf_ov) begin
			// Idle between plays: low, nothing blanked
			next_s.ev = 4'h0;
			next_s.blank = 1'b0;
			next_s.hold = 1'b0;
			next_s.samp = 1'b0;
		end
	end

	// Single register stage for all state
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			s <= '0;
			s.aw_rdy <= 1'b1;
			s.w_rdy <= 1'b1;
			s.ar_rdy <= 1'b1;
			s.pol <= POL_RST;
			s.men <= EN_RST;
			s.blk_rt <= RT_NONE;
			s.hld_rt <= RT_NONE;
		end else begin
			s <= next_s;
		end
	end

	assign S_AXI_AWREADY = s.aw_rdy;
	assign S_AXI_WREADY = s.w_rdy;
	assign S_AXI_BVALID = s.bvalid;
	assign S_AXI_BRESP = s.bresp;
	assign S_AXI_ARREADY = s.ar_rdy;
	assign S_AXI_RVALID = s.rvalid;
	assign S_AXI_RDATA = s.rdata;
	assign S_AXI_RRESP = s.rresp;
	assign EVENT = s.ev;
	assign RF_BLANK = s.blank;
	assign LEVEL_HOLD = s.hold;
	assign LEVEL_SAMPLE = s.samp;

	// Checks on the edit engine and output stage
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	sequence SQ_SET_GO;
		apply && s.es == ES_IDLE && s.resident && range_ok &&
			next_s.op == OP_SET;
	endsequence
	sequence SQ_START;
		s.es == ES_IDLE ##1 s.es == ES_RUN;
	endsequence

	AST_SET_KEEPS: assert property (bm_we != 4'h0 && s.eop != OP_CLR
		|-> bm_wd) else $error("set wrote a zero");
	AST_RANGE_START: assert property (SQ_SET_GO |=> bm_we != 4'h0 &&
		bm_wa == IW'(s.first - 1'b1)) else $error("bad start");
	AST_RANGE_END: assert property (s.es == ES_RUN &&
		s.eidx == s.elast |=> s.es == ES_IDLE)
		else $error("walk overran");
	AST_CLR_ALL: assert property (s.es == ES_RUN && s.eop == OP_CLR
		|-> bm_we != 4'h0 && !bm_wd) else $error("clear gap");
	AST_FIRST: assert property (s.es == ES_RUN && s.eop == OP_FIRST
		|-> bm_wa == '0 ##1 s.es == ES_IDLE)
		else $error("first point wrong");
	AST_SKIP: assert property (bm_we != 4'h0 && s.esk != '0 &&
		s.eidx != s.elast |=> bm_we == 4'h0)
		else $error("skip missed");
	AST_CLAMP: assert property (SQ_START |-> s.esk <= s.elast - s.eidx)
		else $error("skip too large");
	AST_REFUSE: assert property (apply && s.es == ES_IDLE &&
		!s.resident |=> s.refused && s.es == ES_IDLE)
		else $error("edit not refused");
	AST_MASK: assert property (push |-> (buf_id & ~s.men) == 4'h0)
		else $error("disabled marker passed");
	AST_POL: assert property (pop |=> EVENT == ($past(buf_od) ^
		$past(s.pol))) else $error("polarity wrong");
	AST_BLANK: assert property (pop && s.blk_rt == 3'd1 |=>
		RF_BLANK == !EVENT[0] && (!RF_BLANK || LEVEL_HOLD))
		else $error("blank wrong");
endmodule
`default_nettype wire

// File: tb/wmg_meter.sv
`default_nettype none
// Measuring instrument on the event outputs
module wmg_meter (
	input wire logic clk,
	input wire logic rec,
	input wire logic stall,
	input wire logic [6:0] smp,
	output logic evt_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [6:0] got [$]; // Captured output samples
	int cnt; // Pacing counter
	logic arm; // First edge of a run only loads
	// Slow mode takes one sample in three, so the buffer must fill
	always @(posedge clk) begin
		cnt <= cnt + 1;
		evt_ready <= !stall || (cnt % 3 == 0);
	end
	// Record what each accepting edge put on the outputs
	always @(posedge clk) begin
		if (!rec) begin
			arm = 1'h0;
		end else begin
			if (arm && evt_ready) begin
				#1;
				got.push_back(smp);
			end
			arm = 1'h1;
		end
	end
endmodule
`default_nettype wire

// File: tb/waveform_marker_generator_tb.sv
`default_nettype none
// Bench for the marker generator
module waveform_marker_generator_tb import wmg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SL = 16; // Segment length in points
	logic mclk, rst, play, stall, rec, erdy;
	logic [7:0] awa, ara;
	logic awv, awr, wv, wrdy, bv, bry, arv, arr, rv, rry;
	logic [31:0] wd, rd;
	logic [3:0] ws, evt;
	logic [1:0] br, rr;
	logic blk, hld, smp;
	logic [3:0] ex [SL]; // Expected flags per point
	logic [3:0] pol, en; // Expected polarity and enables
	logic [2:0] rb, rh; // Expected blank and hold routes
	int n_errors, n_compared;

	wmg_top #(.DEPTH(64), .PW(16)) i_dut (.MCLK(mclk), .RST(rst),
		.S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wrdy), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr),
		.S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .PLAY(play),
		.EVT_READY(erdy), .EVENT(evt), .RF_BLANK(blk),
		.LEVEL_HOLD(hld), .LEVEL_SAMPLE(smp));
	wmg_meter i_meter (.clk(mclk), .rec(rec), .stall(stall),
		.smp({smp, hld, blk, evt}), .evt_ready(erdy));

	// Free-running sample clock
	initial begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %0t: got %0h expected %0h", $time, g, e);
		end
	endtask

	task automatic end_of_test;
		$display("Compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Bus write; both channels offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		bit ad, wdn;
		ad = 0;
		wdn = 0;
		@(posedge mclk);
		awa <= a;
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		bry <= 1'h1;
		while (!(ad && wdn)) begin
			@(posedge mclk);
			if (!ad && awr) begin
				ad = 1;
				awv <= 1'h0;
			end
			if (!wdn && wrdy) begin
				wdn = 1;
				wv <= 1'h0;
			end
		end
		do @(posedge mclk); while (!bv);
		r = br;
		bry <= 1'h0;
	endtask

	// Bus read; ready held until the answer is seen
	task automatic rdr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge mclk);
		ara <= a;
		arv <= 1'h1;
		rry <= 1'h1;
		do @(posedge mclk); while (!arr);
		arv <= 1'h0;
		while (!rv) @(posedge mclk);
		d = rd;
		r = rr;
		rry <= 1'h0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rdr(a, d, r);
		chk(d, e);
	endtask

	task automatic cfg(input logic [3:0] p, input logic [3:0] e,
		input logic [2:0] b, input logic [2:0] h);
		logic [1:0] r;
		pol = p;
		en = e;
		rb = b;
		rh = h;
		wr(OFS_CFG, {8'h00, e, 3'h0, 1'h1, 5'h00, h, 1'h0, b, p}, r);
		chk(r, RESP_OKAY);
	endtask

	// One edit, then the same edit applied to the expected map
	task automatic edit(input int s, input wmg_op_e op, input int f,
		input int l, input int k);
		logic [31:0] d;
		logic [1:0] r;
		int e, t;
		wr(OFS_FIRST, f, r);
		wr(OFS_LAST, l, r);
		wr(OFS_SKIP, k, r);
		wr(OFS_CTRL, 32'(s) | (32'(op) << CTL_OP_LSB) | 32'h10, r);
		t = 0;
		do begin
			rdr(OFS_STAT, d, r);
			t++;
		end while (d[ST_BUSY] !== 1'h0 && t < 100);
		chk(d[ST_BUSY], 1'h0);
		e = (k < l - f) ? k : l - f; // Spacing never wider than range
		for (int p = f; p <= l; p++) begin
			if (op == OP_CLR) ex[p-1][s] = 1'h0;
			else if (op == OP_SET && (p - f) % (e + 1) == 0) ex[p-1][s] = 1'h1;
		end
		if (op == OP_FIRST) ex[0][s] = 1'h1;
	endtask

	function automatic logic [6:0] expv(input int p);
		logic [3:0] l;
		logic b, h, s;
		l = (ex[p] & en) ^ pol;
		b = rb != 0 && !l[rb-1];
		h = b || (rh != 0 && !l[rh-1]);
		s = rh != 0 && l[rh-1];
		return {s, h, b, l};
	endfunction

	// Play at least n points, compare the first n captured samples, then stop
	task automatic playchk(input int n, input logic st);
		@(posedge mclk);
		// Meter may still push one late sample after the last run
		i_meter.got.delete();
		stall <= st;
		rec <= 1'h1;
		play <= 1'h1;
		repeat (n * 4 + 8) @(posedge mclk);
		play <= 1'h0;
		rec <= 1'h0;
		chk(i_meter.got.size() >= n, 1);
		for (int i = 0; i < n; i++) begin
			chk(i_meter.got[i], expv(i % SL));
		end
		repeat (10) @(posedge mclk);
		chk({smp, hld, blk, evt}, 0);
	endtask

	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		rchk(OFS_CFG, {8'h00, EN_RST, 16'h0000, POL_RST});
		rchk(OFS_STAT, 32'h0);
		rdr(8'h1C, d, r);
		chk(d, 32'h0);
		chk(r, RESP_SLVERR);
		wr(8'h1C, 32'hFFFFFFFF, r);
		chk(r, RESP_SLVERR);
	endtask

	// Edits refused when not resident or beyond the segment
	task automatic t_refuse;
		logic [1:0] r;
		wr(OFS_SEGLEN, SL, r);
		wr(OFS_FIRST, 1, r);
		wr(OFS_LAST, 2, r);
		wr(OFS_CTRL, 32'h15, r);
		rchk(OFS_STAT, 32'h2);
		wr(OFS_STAT, 32'h2, r);
		rchk(OFS_STAT, 32'h0);
		cfg(4'h0, 4'hF, 3'h0, 3'h0);
		wr(OFS_LAST, SL + 1, r);
		wr(OFS_CTRL, 32'h15, r);
		rchk(OFS_STAT, 32'h2);
		wr(OFS_STAT, 32'h2, r);
	endtask

	task automatic t_edits;
		playchk(SL, 1'h0);
		edit(0, OP_SET, 3, 6, 0);
		edit(1, OP_SET, 9, 9, 0);
		edit(2, OP_FIRST, 1, 1, 0);
		edit(3, OP_SET, 2, 8, 1);
		edit(3, OP_SET, 12, 14, 20);
		edit(0, OP_SET, 10, 10, 0);
		edit(0, OP_CLR, 4, 5, 0);
		edit(1, OP_SET, SL, SL, 0);
		playchk(2 * SL, 1'h0);
	endtask

	// Polarity, masks and routing, with a slow consumer
	task automatic t_route;
		cfg(4'h6, 4'hD, 3'h3, 3'h4);
		playchk(SL, 1'h1);
		cfg(4'h9, 4'hF, 3'h4, 3'h1);
		playchk(SL, 1'h0);
	endtask

	// Hang guard
	initial begin
		repeat (30000) @(posedge mclk);
		n_errors++;
		end_of_test;
	end

	initial begin
		n_errors = 0;
		n_compared = 0;
		rst = 1'h1;
		{play, stall, rec, awv, wv, bry, arv, rry} = 8'h00;
		awa = 8'h00;
		ara = 8'h00;
		wd = 32'h0;
		ws = 4'hF;
		{pol, en, rb, rh} = {4'h0, 4'hF, 6'h00};
		foreach (ex[i]) ex[i] = 4'h0;
		repeat (4) @(posedge mclk);
		rst <= 1'h0;
		t_reset;
		t_refuse;
		t_edits;
		t_route;
		end_of_test;
	end
endmodule
`default_nettype wire
